/* File: rtl/eipb_pkg.sv */
// constants for the extended interrupt priority bank
package eipb_pkg;
    // register map: 0xF6 is the register index; each register owns one aligned word,
    // so its byte address is four times the index and its bits sit in lane 0
    localparam logic [7:0] EIPB_IDX_PRIO1 = 8'hF6;
    localparam logic [9:0] EIPB_ADDR_PRIO1 = {EIPB_IDX_PRIO1, 2'h0};
    localparam logic [7:0] EIPB_PRIO1_RESET = 8'h00;
    // writable bits; bit 1 is reserved and reads zero
    localparam logic [7:0] EIPB_PRIO1_WMASK = 8'hFD;
    // field positions
    localparam int EIPB_BIT_TIMER3 = 7;
    localparam int EIPB_BIT_CMP1 = 6;
    localparam int EIPB_BIT_CMP0 = 5;
    localparam int EIPB_BIT_PCA = 4;
    localparam int EIPB_BIT_CONV = 3;
    localparam int EIPB_BIT_WIN = 2;
    localparam int EIPB_BIT_SMB = 0;
    // AXI responses
    localparam logic [1:0] EIPB_RESP_OKAY = 2'h0;
    localparam logic [1:0] EIPB_RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/eipb_prio_reg.sv */
// the 8-bit priority select register with byte-lane write
`timescale 1ns/100ps
module eipb_prio_reg (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    // stored value
    output logic [7:0] value_out
);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= eipb_pkg::EIPB_PRIO1_RESET;
        end else if (wr_en_in) begin
            // reserved bit is never stored so it always reads zero
            value_out <= wr_data_in & eipb_pkg::EIPB_PRIO1_WMASK; // RQ6
        end
    end
endmodule

/* File: rtl/eipb_top.sv */
// AXI4-Lite slave holding the extended interrupt priority register
// What this block does
// RQ1: bit 7 sets timer 3 interrupt priority, 0 low, 1 high.
// RQ2: bit 5 sets comparator 0 interrupt priority, 0 low, 1 high.
// RQ3: bit 4 sets counter array interrupt priority, 0 low, 1 high.
// RQ4: bit 3 sets ADC conversion-complete interrupt priority, 0 low, 1 high.
// RQ5: bit 2 sets ADC window-compare interrupt priority, 0 low, 1 high.
// RQ6: bit 6 comparator 1, bit 0 SMBus priority; bit 1 reserved.
`timescale 1ns/100ps
module eipb_top (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // AXI4-Lite write address
    input wire logic [9:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read address
    input wire logic [9:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // per-source priority levels to the core arbiter, 1 = high
    output logic timer3_prio_sel_out,
    output logic comparator1_prio_sel_out,
    output logic comparator0_prio_sel_out,
    output logic counter_array_prio_sel_out,
    output logic conv_done_prio_sel_out,
    output logic window_cmp_prio_sel_out,
    output logic smbus_prio_sel_out
);
    logic [9:0] aw_addr_reg;
    logic aw_held_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic w_held_reg;
    logic [7:0] prio_value;
    logic reg_wr_en;
    logic wr_hit;

    // the register owns one aligned word; address bits [1:0] are not decoded
    function automatic logic addr_hit(input logic [9:0] addr);
        addr_hit = (addr[9:2] == eipb_pkg::EIPB_ADDR_PRIO1[9:2]);
    endfunction

    // address and data are taken independently, one write in flight
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_in;
        end else if (reg_wr_en || (aw_held_reg && w_held_reg)) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in[7:0];
            w_lane0_reg <= s_axi_wstrb_in[0];
        end else if (aw_held_reg && w_held_reg) begin
            w_held_reg <= 1'b0;
        end
    end

    // ready is registered low while an item is held or a response is pending,
    // and for one cycle after each handshake so a still-held valid is not taken twice
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_held_reg && !s_axi_bvalid_out
                && !(s_axi_awvalid_in && s_axi_awready_out);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= !w_held_reg && !s_axi_bvalid_out
                && !(s_axi_wvalid_in && s_axi_wready_out);
        end
    end

    assign wr_hit = addr_hit(aw_addr_reg);
    assign reg_wr_en = aw_held_reg && w_held_reg && wr_hit && w_lane0_reg;

    // response rises once both halves are held; the register is written at that same edge
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
        end else if (aw_held_reg && w_held_reg) begin
            s_axi_bvalid_out <= 1'b1;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // an unmapped word is refused with an error and leaves the register untouched
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_bresp_out <= eipb_pkg::EIPB_RESP_OKAY;
        end else if (aw_held_reg && w_held_reg) begin
            s_axi_bresp_out <= wr_hit ? eipb_pkg::EIPB_RESP_OKAY : eipb_pkg::EIPB_RESP_SLVERR;
        end
    end

    eipb_prio_reg u_prio (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(reg_wr_en),
        .wr_data_in(w_data_reg),
        .value_out(prio_value)
    );

    // read channel: one cycle from address taken to data valid
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b0;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid_out <= 1'b0;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // data and response are captured at the address handshake and stand until rready
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= eipb_pkg::EIPB_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            if (addr_hit(s_axi_araddr_in)) begin
                s_axi_rdata_out <= {24'h000000, prio_value};
                s_axi_rresp_out <= eipb_pkg::EIPB_RESP_OKAY;
            end else begin
                s_axi_rdata_out <= 32'h00000000;
                s_axi_rresp_out <= eipb_pkg::EIPB_RESP_SLVERR;
            end
        end
    end

    // outputs registered so they change one cycle after the register;
    // the arbiter sees a clean level with no decode glitch from the bus side
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer3_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_TIMER3];
        end else begin
            timer3_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_TIMER3]; // RQ1
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comparator1_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_CMP1];
        end else begin
            comparator1_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_CMP1]; // RQ6
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comparator0_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_CMP0];
        end else begin
            comparator0_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_CMP0]; // RQ2
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            counter_array_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_PCA];
        end else begin
            counter_array_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_PCA]; // RQ3
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_done_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_CONV];
        end else begin
            conv_done_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_CONV]; // RQ4
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            window_cmp_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_WIN];
        end else begin
            window_cmp_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_WIN]; // RQ5
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smbus_prio_sel_out <= eipb_pkg::EIPB_PRIO1_RESET[eipb_pkg::EIPB_BIT_SMB];
        end else begin
            smbus_prio_sel_out <= prio_value[eipb_pkg::EIPB_BIT_SMB]; // RQ6
        end
    end
endmodule

/* File: testbench/eipb_arb_model.sv */
// core-side model gathering the per-source priority levels
`timescale 1ns/100ps
module eipb_arb_model (
    // levels from the bank, bit 6 timer 3 down to bit 0 smbus
    input wire logic [6:0] prio_in,
    // one bit per register position, 1 = high
    output logic [7:0] high_vec_out
);
    // position 1 has no source behind it, so it never reports high
    assign high_vec_out = {prio_in[6:1], 1'b0, prio_in[0]};
endmodule

/* File: testbench/eipb_prio_properties.sv */
// assertions on the priority bank ports
`timescale 1ns/100ps
module eipb_prio_properties (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // write data and response
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [1:0] s_axi_bresp_out,
    // priority levels
    input wire logic timer3_prio_sel_out,
    input wire logic comparator1_prio_sel_out,
    input wire logic comparator0_prio_sel_out,
    input wire logic counter_array_prio_sel_out,
    input wire logic conv_done_prio_sel_out,
    input wire logic window_cmp_prio_sel_out,
    input wire logic smbus_prio_sel_out
);
    logic [7:0] cap;
    logic cap_en;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // lane 0 of the last accepted write beat
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cap <= 8'h00;
            cap_en <= 1'b0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            cap <= s_axi_wdata_in[7:0];
            cap_en <= s_axi_wstrb_in[0];
        end
    end
    sequence s_wr_ok;
        $rose(s_axi_bvalid_out) && s_axi_bresp_out == eipb_pkg::EIPB_RESP_OKAY && cap_en;
    endsequence
    a_timer3_level: assert property (s_wr_ok |=> timer3_prio_sel_out == cap[7]) else $error("bad t3");
    a_cmp0_level: assert property (s_wr_ok |=> comparator0_prio_sel_out == cap[5]) else $error("bad c0");
    a_pca_level: assert property (s_wr_ok |=> counter_array_prio_sel_out == cap[4]) else $error("bad pca");
    a_conv_level: assert property (s_wr_ok |=> conv_done_prio_sel_out == cap[3]) else $error("bad conv");
    a_win_level: assert property (s_wr_ok |=> window_cmp_prio_sel_out == cap[2]) else $error("bad win");
    a_cmp1_smb_level: assert property (s_wr_ok |=> {comparator1_prio_sel_out, smbus_prio_sel_out} ==
        {cap[6], cap[0]}) else $error("bad c1 smb");
endmodule
bind eipb_top eipb_prio_properties u_props (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .timer3_prio_sel_out(timer3_prio_sel_out),
    .comparator1_prio_sel_out(comparator1_prio_sel_out),
    .comparator0_prio_sel_out(comparator0_prio_sel_out),
    .counter_array_prio_sel_out(counter_array_prio_sel_out),
    .conv_done_prio_sel_out(conv_done_prio_sel_out),
    .window_cmp_prio_sel_out(window_cmp_prio_sel_out),
    .smbus_prio_sel_out(smbus_prio_sel_out)
);

/* File: testbench/tb.sv */
// self-checking bench for the priority bank
`timescale 1ns/100ps
module tb;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [9:0] s_axi_awaddr_in = 10'h000, s_axi_araddr_in = 10'h000;
    logic [7:0] high_vec, v;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, bq[$];
    logic timer3_prio_sel_out, comparator1_prio_sel_out, comparator0_prio_sel_out, counter_array_prio_sel_out;
    logic conv_done_prio_sel_out, window_cmp_prio_sel_out, smbus_prio_sel_out;
    logic [33:0] rq[$];
    int num_errors = 0, total_checks = 0;
    eipb_top dut (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(s_axi_awaddr_in),
        .s_axi_awvalid_in(s_axi_awvalid_in),
        .s_axi_awready_out(s_axi_awready_out),
        .s_axi_wdata_in(s_axi_wdata_in),
        .s_axi_wstrb_in(s_axi_wstrb_in),
        .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out),
        .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_bvalid_out(s_axi_bvalid_out),
        .s_axi_bready_in(s_axi_bready_in),
        .s_axi_araddr_in(s_axi_araddr_in),
        .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out),
        .s_axi_rdata_out(s_axi_rdata_out),
        .s_axi_rresp_out(s_axi_rresp_out),
        .s_axi_rvalid_out(s_axi_rvalid_out),
        .s_axi_rready_in(s_axi_rready_in),
        .timer3_prio_sel_out(timer3_prio_sel_out),
        .comparator1_prio_sel_out(comparator1_prio_sel_out),
        .comparator0_prio_sel_out(comparator0_prio_sel_out),
        .counter_array_prio_sel_out(counter_array_prio_sel_out),
        .conv_done_prio_sel_out(conv_done_prio_sel_out),
        .window_cmp_prio_sel_out(window_cmp_prio_sel_out),
        .smbus_prio_sel_out(smbus_prio_sel_out)
    );
    eipb_arb_model u_core (.prio_in({timer3_prio_sel_out, comparator1_prio_sel_out, comparator0_prio_sel_out,
        counter_array_prio_sel_out, conv_done_prio_sel_out, window_cmp_prio_sel_out, smbus_prio_sel_out}),
        .high_vec_out(high_vec));
    always #5 mclk_in = ~mclk_in;
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // answers are matched in arrival order against the notes left by the drivers
    always @(posedge mclk_in) begin
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            cmp("bresp", bq.pop_front(), s_axi_bresp_out);
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            cmp("rdata", rq.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
        end
    end
    task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit bd = 0;
        bq.push_back(er);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        for (int n = 0; n < 40 && !bd; n++) begin
            @(posedge mclk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out) begin
                s_axi_bready_in <= 1'b0;
                bd = 1'b1;
            end
        end
        if (!bd) begin
            num_errors++;
            final_report();
        end
        // an idle edge so the next call never re-raises bready in the same time step
        @(posedge mclk_in);
    endtask
    task automatic axi_rd(input logic [9:0] a, input logic [33:0] e);
        bit rd = 0;
        rq.push_back(e);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        for (int n = 0; n < 40 && !rd; n++) begin
            @(posedge mclk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out) begin
                s_axi_rready_in <= 1'b0;
                rd = 1'b1;
            end
        end
        if (!rd) begin
            num_errors++;
            final_report();
        end
        @(posedge mclk_in);
    endtask
    // other lanes carry junk so a wrong lane shows up
    task automatic check_val(input logic [7:0] d, input logic [3:0] s, input logic [9:0] a, input logic [1:0] er,
        input logic [7:0] e);
        axi_wr(a, {24'h5AC3C3, d}, s, er);
        repeat (2) @(posedge mclk_in);
        cmp("prio", {26'h0, e}, {26'h0, high_vec});
        axi_rd(eipb_pkg::EIPB_ADDR_PRIO1, {eipb_pkg::EIPB_RESP_OKAY, 24'h000000, e});
        $display("test done data %h", d);
    endtask
    initial begin
        void'($urandom(32'hCBC2));
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        axi_rd(eipb_pkg::EIPB_ADDR_PRIO1, {eipb_pkg::EIPB_RESP_OKAY, 32'h0});
        for (int b = 0; b < 8; b++) begin
            v = 8'h01 << b;
            check_val(v, 4'hF, eipb_pkg::EIPB_ADDR_PRIO1, 2'h0, v & 8'hFD);
        end
        // lane 0 strobe off: the register keeps its value
        check_val(8'h00, 4'hE, eipb_pkg::EIPB_ADDR_PRIO1, 2'h0, 8'h80);
        check_val(8'h55, 4'hF, 10'h010, eipb_pkg::EIPB_RESP_SLVERR, 8'h80);
        // the index itself is not the byte address, so it must be refused
        axi_rd(10'h0F6, {eipb_pkg::EIPB_RESP_SLVERR, 32'h0});
        repeat (4) begin
            v = 8'($urandom);
            check_val(v, 4'hF, eipb_pkg::EIPB_ADDR_PRIO1, 2'h0, v & 8'hFD);
        end
        final_report();
    end
endmodule
